/* File: src/pbmc_top.sv */
// Basic mode control register with MII gating, AXI4-Lite slave
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pbmc_top #(
	parameter int DEAD_CNT = pbmc_pkg::DEAD_CYCLES
) (
	// Clock, reset, enable
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              ce,
	// AXI4-Lite write
	input  wire logic [31:0]       s_awaddr,
	input  wire logic              s_awvalid,
	output logic                   s_awready,
	input  wire logic [31:0]       s_wdata,
	input  wire logic [3:0]        s_wstrb,
	input  wire logic              s_wvalid,
	output logic                   s_wready,
	output logic [1:0]             s_bresp,
	output logic                   s_bvalid,
	input  wire logic              s_bready,
	// AXI4-Lite read
	input  wire logic [31:0]       s_araddr,
	input  wire logic              s_arvalid,
	output logic                   s_arready,
	output logic [31:0]            s_rdata,
	output logic [1:0]             s_rresp,
	output logic                   s_rvalid,
	input  wire logic              s_rready,
	// Auto-negotiation engine
	input  wire logic              an_started,
	input  wire logic              an_speed100,
	input  wire logic              an_full_dplx,
	output logic                   an_enable,
	output logic                   an_restart,
	// Datapath control
	output logic                   dp_speed100,
	output logic                   dp_full_dplx,
	output logic                   dp_loopback,
	output logic                   dp_power_down,
	output logic                   dp_soft_reset,
	output logic                   rx_dead_window,
	// MII from MAC (asynchronous pins)
	input  wire pbmc_pkg::pbmc_tx_s mii_tx_pin,
	output pbmc_pkg::pbmc_tx_s     mii_tx_core,
	// MII toward MAC
	input  wire pbmc_pkg::pbmc_rx_s mii_rx_core,
	output pbmc_pkg::pbmc_rx_s     mii_rx_o,
	output logic                   mii_rx_oe
);
	import pbmc_pkg::*;

	// Zero would make the dead window vanish without notice
	if (DEAD_CNT < 1) begin : g_bad_dead
		$error("DEAD_CNT must be at least one");
	end

	logic [15:0]  ctl_reg;
	logic [15:0]  ctl_next;
	pbmc_state_e  st_reg;
	logic [4:0]   srst_cnt_reg;
	logic [31:0]  dead_cnt_reg;
	pbmc_tx_s     tx_s1_reg;
	pbmc_tx_s     tx_s2_reg;
	pbmc_rx_s     rx_out_reg;
	logic         aw_got_reg;
	logic         w_got_reg;
	logic [31:0]  awaddr_reg;
	logic [31:0]  wdata_reg;
	logic [3:0]   wstrb_reg;

	// Write channel capture; address and data accepted in either order
	assign s_awready = !aw_got_reg && !s_bvalid;
	assign s_wready  = !w_got_reg && !s_bvalid;
	wire        aw_now  = s_awvalid && s_awready;
	wire        w_now   = s_wvalid && s_wready;
	wire        aw_have = aw_got_reg || aw_now;
	wire        w_have  = w_got_reg || w_now;
	wire [31:0] waddr   = aw_got_reg ? awaddr_reg : s_awaddr;
	wire [31:0] wdat    = w_got_reg ? wdata_reg : s_wdata;
	wire [3:0]  wstb    = w_got_reg ? wstrb_reg : s_wstrb;
	wire        wr_go   = aw_have && w_have && !s_bvalid;
	wire        wr_bmc  = wr_go && (waddr == BMC_OFFSET);
	wire        wr_ctl  = wr_go && (waddr == CTL_OFFSET);
	wire        wr_hit  = wr_bmc || wr_ctl;

	// Byte lanes of the 16-bit register
	wire [15:0] lane_mask = {{8{wstb[1]}}, {8{wstb[0]}}};
	wire [15:0] wmask     = lane_mask & BMC_WMASK;
	wire [15:0] wval      = wdat[15:0];

	wire an_on     = ctl_reg[ANEN_BIT];
	wire in_srst   = (st_reg == ST_SRST);

	// Visible value: negotiated speed and duplex shown while autoneg on
	wire rd_speed  = an_on ? an_speed100 : ctl_reg[SPEED_BIT];
	wire rd_duplex = an_on ? an_full_dplx : ctl_reg[DUPLEX_BIT];
	wire [15:0] bmc_view = {in_srst, ctl_reg[14:14], rd_speed,
		ctl_reg[12:9], rd_duplex, ctl_reg[7:7], 7'h00};

	// A write setting restart beats the engine's acknowledgement
	wire restart_set = wr_bmc && wmask[RESTART_BIT] && wval[RESTART_BIT];

	// Next control value
	always_comb begin
		ctl_next = ctl_reg;
		if (wr_bmc) begin
			ctl_next = (ctl_reg & ~wmask) | (wval & wmask);
			// Restart only sets; a zero written to it never aborts negotiation, but clearing ANEN does
			ctl_next[RESTART_BIT] = ctl_reg[RESTART_BIT] ||
				(wmask[RESTART_BIT] && wval[RESTART_BIT] &&
				 ctl_next[ANEN_BIT]);
			ctl_next[RST_BIT] = 1'b0;
		end
		if (!ctl_next[ANEN_BIT]) begin
			ctl_next[RESTART_BIT] = 1'b0;
		end
		// Set wins over the engine's acknowledgement only on a new write
		if (an_started && ctl_reg[RESTART_BIT] && !restart_set) begin
			ctl_next[RESTART_BIT] = 1'b0;
		end
	end

	wire srst_req = wr_bmc && wmask[RST_BIT] && wval[RST_BIT];

	// Control register and soft reset sequence
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctl_reg      <= BMC_RESET;
			st_reg       <= ST_RUN;
			srst_cnt_reg <= 5'h00;
		end else if (ce) begin
			case (st_reg)
				ST_RUN: begin
					if (srst_req) begin
						ctl_reg      <= BMC_RESET;
						st_reg       <= ST_SRST;
						srst_cnt_reg <= 5'(SRST_CYCLES - 1);
					end else begin
						ctl_reg <= ctl_next;
					end
				end
				ST_SRST: begin
					// Writes during the sequence are dropped
					if (srst_cnt_reg == 5'h00) begin
						st_reg <= ST_RUN;
					end else begin
						srst_cnt_reg <= srst_cnt_reg - 5'h01;
					end
				end
				default: begin
					st_reg <= ST_RUN;
				end
			endcase
		end
	end

	// Write response; unmapped address gives SLVERR
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aw_got_reg <= 1'b0;
			w_got_reg  <= 1'b0;
			awaddr_reg <= 32'h0000_0000;
			wdata_reg  <= 32'h0000_0000;
			wstrb_reg  <= 4'h0;
			s_bvalid   <= 1'b0;
			s_bresp    <= RESP_OKAY;
		end else if (ce) begin
			if (aw_now) begin
				awaddr_reg <= s_awaddr;
			end
			if (w_now) begin
				wdata_reg <= s_wdata;
				wstrb_reg <= s_wstrb;
			end
			if (wr_go) begin
				aw_got_reg <= 1'b0;
				w_got_reg  <= 1'b0;
				s_bvalid   <= 1'b1;
				s_bresp    <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else begin
				aw_got_reg <= aw_have;
				w_got_reg  <= w_have;
				if (s_bvalid && s_bready) begin
					s_bvalid <= 1'b0;
				end
			end
		end
	end

	// Read channel; served in every mode, including power down and isolate
	assign s_arready = !s_rvalid;
	wire        rd_go  = s_arvalid && s_arready;
	wire        rd_bmc = (s_araddr == BMC_OFFSET);
	wire        rd_ctl = (s_araddr == CTL_OFFSET);
	wire [31:0] ctl_view = {30'h0, rx_dead_window, in_srst};
	wire [31:0] rd_val = rd_bmc ? {16'h0000, bmc_view} :
		rd_ctl ? ctl_view : 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_rvalid <= 1'b0;
			s_rdata  <= 32'h0000_0000;
			s_rresp  <= RESP_OKAY;
		end else if (ce) begin
			if (rd_go) begin
				s_rvalid <= 1'b1;
				s_rdata  <= rd_val;
				s_rresp  <= (rd_bmc || rd_ctl) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_rvalid && s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end

	// Effective datapath controls follow writes immediately
	assign an_enable     = an_on;
	assign an_restart    = ctl_reg[RESTART_BIT];
	assign dp_speed100   = rd_speed;
	assign dp_full_dplx  = rd_duplex;
	assign dp_loopback   = ctl_reg[LOOP_BIT];
	assign dp_power_down = ctl_reg[PDOWN_BIT];
	assign dp_soft_reset = in_srst;

	// Dead time after entering loopback at 100M; receive may be invalid
	// Limitation: a speed change while already looped does not rearm it
	// Speed after this edge; one write may force 100M and loopback at once
	wire nx_spd    = ctl_next[ANEN_BIT] ? an_speed100 : ctl_next[SPEED_BIT];
	wire loop_rise = srst_req ? 1'b0 : (ctl_next[LOOP_BIT] &&
		!ctl_reg[LOOP_BIT] && nx_spd && !in_srst);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dead_cnt_reg <= 32'h0000_0000;
		end else if (ce) begin
			if (loop_rise) begin
				dead_cnt_reg <= 32'(DEAD_CNT);
			end else if (!ctl_reg[LOOP_BIT]) begin
				dead_cnt_reg <= 32'h0000_0000;
			end else if (dead_cnt_reg != 32'h0000_0000) begin
				dead_cnt_reg <= dead_cnt_reg - 32'h0000_0001;
			end
		end
	end
	assign rx_dead_window = (dead_cnt_reg != 32'h0000_0000);

	// Transmit pins cross into the clock domain through two stages
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_s1_reg <= '0;
			tx_s2_reg <= '0;
		end else if (ce) begin
			tx_s1_reg <= mii_tx_pin;
			tx_s2_reg <= tx_s1_reg;
		end
	end
	wire tx_block = ctl_reg[ISO_BIT] || ctl_reg[PDOWN_BIT] || in_srst;
	assign mii_tx_core = tx_block ? '0 : tx_s2_reg;

	// Receive outputs registered; held quiet in power down so no glitches
	wire quiet = ctl_reg[PDOWN_BIT] || ctl_next[PDOWN_BIT];
	pbmc_rx_s rx_next;
	always_comb begin
		rx_next = mii_rx_core;
		if (ctl_reg[COLT_BIT]) begin
			rx_next.col = mii_rx_core.col || tx_s2_reg.tx_en;
		end
		if (quiet) begin
			rx_next = '0;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_out_reg <= '0;
		end else if (ce) begin
			rx_out_reg <= rx_next;
		end
	end
	assign mii_rx_o  = rx_out_reg;
	// Low oe lets the pads float the MII outputs
	assign mii_rx_oe = !ctl_reg[ISO_BIT];
endmodule : pbmc_top
`default_nettype wire

/* File: src/pbmc_pkg.sv */
// Package for the basic mode control register block
package pbmc_pkg;
	localparam logic [31:0] BMC_OFFSET    = 32'h0000_0000;
	localparam logic [31:0] CTL_OFFSET    = 32'h0000_0004;
	localparam int          RST_BIT       = 15;
	localparam int          LOOP_BIT      = 14;
	localparam int          SPEED_BIT     = 13;
	localparam int          ANEN_BIT      = 12;
	localparam int          PDOWN_BIT     = 11;
	localparam int          ISO_BIT       = 10;
	localparam int          RESTART_BIT   = 9;
	localparam int          DUPLEX_BIT    = 8;
	localparam int          COLT_BIT      = 7;
	localparam logic [15:0] BMC_RESET     = 16'h3100;
	localparam logic [15:0] BMC_WMASK     = 16'hFF80;
	localparam int          CLK_HZ        = 50_000_000;
	localparam int          DEAD_MS       = 720;
	localparam int          DEAD_CYCLES   = DEAD_MS * (CLK_HZ / 1000);
	localparam int          SRST_CYCLES   = 16;
	localparam logic [1:0]  RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR   = 2'b10;

	typedef struct packed {
		logic [3:0] txd;
		logic       tx_en;
		logic       tx_er;
	} pbmc_tx_s;

	typedef struct packed {
		logic       rx_clk;
		logic       tx_clk;
		logic       rx_dv;
		logic       rx_er;
		logic [3:0] rxd;
		logic       col;
		logic       crs;
	} pbmc_rx_s;

	typedef enum logic [1:0] {
		ST_RUN  = 2'b00,
		ST_SRST = 2'b01
	} pbmc_state_e;
endpackage : pbmc_pkg

/* File: tb/pbmc_far.sv */
// Far side model: negotiation engine and core receive source
`timescale 1ns/1ps
`default_nettype none
module pbmc_far (
	// Clock and restart request
	input  wire logic          clk,
	input  wire logic          an_restart,
	// Negotiation result and receive source
	output logic               an_started,
	output logic               an_speed100,
	output logic               an_full_dplx,
	output pbmc_pkg::pbmc_rx_s rx
);
	import pbmc_pkg::*;
	logic [9:0] cnt = '0;
	logic [2:0] w = '0;
	logic       n = 1'b0;
	// Result flips with each negotiation, so a stale read shows up
	assign an_speed100 = ~n;
	assign an_full_dplx = n;
	// Collision held low: any COL seen came from the test path
	assign rx = {cnt[8:1], 1'b0, cnt[0]};
	always @(posedge clk) begin
		cnt <= cnt + 10'h001;
		w <= an_restart ? w + 3'h1 : 3'h0;
		an_started <= (w == 3'h5);
		if (w == 3'h5) n <= ~n;
	end
endmodule : pbmc_far
`default_nettype wire

/* File: tb/pbmc_top_asserts.sv */
// Checker for the basic mode control block
`timescale 1ns/1ps
`default_nettype none
module pbmc_top_asserts #(parameter int DEAD_CNT = 20) (
	// Clock and reset
	input wire logic               clk,
	input wire logic               rst_n,
	// Negotiation
	input wire logic               an_enable,
	input wire logic               an_restart,
	input wire logic               an_started,
	input wire logic               an_speed100,
	input wire logic               an_full_dplx,
	// Datapath control
	input wire logic               dp_speed100,
	input wire logic               dp_full_dplx,
	input wire logic               dp_loopback,
	input wire logic               dp_power_down,
	input wire logic               dp_soft_reset,
	input wire logic               rx_dead_window,
	input wire logic               mii_rx_oe,
	// MII
	input wire pbmc_pkg::pbmc_tx_s mii_tx_core,
	input wire pbmc_pkg::pbmc_rx_s mii_rx_o
);
	import pbmc_pkg::*;
	int dc;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// A stuck counter would stretch the window, so its length is bounded
	always_ff @(posedge clk)
		dc <= (!rst_n || !rx_dead_window) ? 0 : dc + 1;
	property p_spd; an_enable |-> dp_speed100 == an_speed100; endproperty
	a_spd: assert property (p_spd) else $error("speed");
	property p_dpx; an_enable |-> dp_full_dplx == an_full_dplx; endproperty
	a_dpx: assert property (p_dpx) else $error("duplex");
	property p_iso; !mii_rx_oe [*4] |-> mii_tx_core == '0; endproperty
	a_iso: assert property (p_iso) else $error("isolate tx");
	property p_pd; dp_power_down [*2] |-> mii_rx_o == '0; endproperty
	a_pd: assert property (p_pd) else $error("power down rx");
	property p_rof; !an_enable |-> !an_restart; endproperty
	a_rof: assert property (p_rof) else $error("restart off");
	property p_rhd;
		an_restart && !an_started && !dp_soft_reset && an_enable
		|=> an_restart || dp_soft_reset || !an_enable;
	endproperty
	a_rhd: assert property (p_rhd) else $error("restart hold");
	property p_dead; $rose(dp_loopback) && dp_speed100 |-> ##[0:2] rx_dead_window;
	endproperty
	a_dead: assert property (p_dead) else $error("dead start");
	property p_dlen; dc <= DEAD_CNT + 1; endproperty
	a_dlen: assert property (p_dlen) else $error("dead length");
	property p_srst;
		$rose(dp_soft_reset) |-> dp_soft_reset [*8] ##[7:12] !dp_soft_reset;
	endproperty
	a_srst: assert property (p_srst) else $error("soft reset");
	c_neg: cover property (an_restart ##[1:10] an_started);
	c_pd: cover property (dp_power_down);
	c_srst: cover property (dp_soft_reset);
endmodule : pbmc_top_asserts
bind pbmc_top pbmc_top_asserts #(.DEAD_CNT(DEAD_CNT)) pbmc_top_asserts_i (
	.clk, .rst_n, .an_enable, .an_restart, .an_started, .an_speed100,
	.an_full_dplx, .dp_speed100, .dp_full_dplx, .dp_loopback,
	.dp_power_down, .dp_soft_reset, .rx_dead_window, .mii_rx_oe,
	.mii_tx_core, .mii_rx_o);
`default_nettype wire

/* File: tb/pbmc_top_tb_top.sv */
// Testbench for the basic mode control block
`timescale 1ns/1ps
`default_nettype none
module pbmc_top_tb_top;
	import pbmc_pkg::*;
	logic clk = 0, rst_n = 0, rnd = 1;
	logic [31:0] s_awaddr = 0, s_wdata = 0, s_araddr = 0, s_rdata;
	logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0;
	logic s_rready = 0, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0] s_bresp, s_rresp;
	logic [3:0] s_wstrb = 4'hF;
	logic an_started, an_speed100, an_full_dplx, an_enable, an_restart;
	logic dp_speed100, dp_full_dplx, dp_loopback, dp_power_down;
	logic dp_soft_reset, rx_dead_window, mii_rx_oe;
	pbmc_tx_s mii_tx_pin = '0, mii_tx_core;
	pbmc_rx_s mii_rx_core, mii_rx_o;
	logic [33:0] qr[$], e;
	logic [1:0] qb[$];
	int n_errors = 0, n_compared = 0;
	wire [31:0] ng = {18'h0, an_speed100, 4'h0, an_full_dplx, 8'h00};
	always #10 clk = ~clk;
	pbmc_top #(.DEAD_CNT(20)) pbmc_top_i (.clk, .rst_n, .ce(1'b1),
		.s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
		.s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
		.s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
		.an_started, .an_speed100, .an_full_dplx, .an_enable, .an_restart,
		.dp_speed100, .dp_full_dplx, .dp_loopback, .dp_power_down,
		.dp_soft_reset, .rx_dead_window, .mii_tx_pin, .mii_tx_core,
		.mii_rx_core, .mii_rx_o, .mii_rx_oe);
	pbmc_far pbmc_far_i (.clk, .an_restart, .an_started, .an_speed100,
		.an_full_dplx, .rx(mii_rx_core));
	task automatic chk(string n, logic [31:0] s, logic [31:0] x);
		n_compared++;
		if (s !== x) begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", n, x, s);
		end
	endtask : chk
	task automatic cyc(int n); repeat (n) @(posedge clk); endtask : cyc
	task automatic wr(logic [31:0] a, d, logic [3:0] s = 4'hF);
		logic ta, tw, b = 0;
		@(posedge clk);
		qb.push_back(RESP_OKAY);
		s_awaddr <= a;
		s_wdata <= d;
		s_wstrb <= s;
		{s_awvalid, s_wvalid, s_bready} <= 3'b111;
		while (!b) begin
			@(negedge clk);
			ta = s_awvalid & s_awready;
			tw = s_wvalid & s_wready;
			b = s_bvalid;
			@(posedge clk);
			if (ta) s_awvalid <= 0;
			if (tw) s_wvalid <= 0;
			if (b) s_bready <= 0;
		end
	endtask : wr
	task automatic rd(logic [31:0] a, x, logic [1:0] r = RESP_OKAY);
		logic ta, b = 0;
		@(posedge clk);
		qr.push_back({r, x});
		s_araddr <= a;
		{s_arvalid, s_rready} <= 2'b11;
		while (!b) begin
			@(negedge clk);
			ta = s_arvalid & s_arready;
			b = s_rvalid;
			@(posedge clk);
			if (ta) s_arvalid <= 0;
			if (b) s_rready <= 0;
		end
	endtask : rd
	// Results are judged mid-cycle, where every output has settled
	always @(negedge clk) begin
		if (s_rvalid && s_rready) begin
			e = qr.pop_front();
			chk("rresp", 32'(s_rresp), 32'(e[33:32]));
			if (e[33:32] == RESP_OKAY) chk("rdata", s_rdata, e[31:0]);
		end
		if (s_bvalid && s_bready) chk("bresp", 32'(s_bresp), 32'(qb.pop_front()));
	end
	always @(posedge clk) if (rnd) mii_tx_pin <= 6'($urandom);
	task stop_test;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		stop_test();
	end
	initial begin
		void'($urandom(8));
		cyc(4);
		rst_n <= 1;
		rd(BMC_OFFSET, 32'h1000 | ng);
		rd(32'h10, 0, RESP_SLVERR);
		wr(BMC_OFFSET, 32'h217F);
		rd(BMC_OFFSET, 32'h2100);
		chk("speed", 32'(dp_speed100), 1);
		chk("duplex", 32'(dp_full_dplx), 1);
		wr(BMC_OFFSET, 32'h0200);
		chk("restart", 32'(an_restart), 0);
		chk("anen", 32'(an_enable), 0);
		chk("speed", 32'(dp_speed100), 0);
		chk("duplex", 32'(dp_full_dplx), 0);
		rd(BMC_OFFSET, 0);
		wr(BMC_OFFSET, 32'h1200);
		chk("restart", 32'(an_restart), 1);
		cyc(12);
		rd(BMC_OFFSET, 32'h1000 | ng);
		wr(BMC_OFFSET, 32'h6100);
		chk("loopback", 32'(dp_loopback), 1);
		rd(CTL_OFFSET, 2);
		cyc(25);
		rd(CTL_OFFSET, 0);
		wr(BMC_OFFSET, 32'h2900);
		chk("pdown", 32'(dp_power_down), 1);
		chk("rxpd", 32'(mii_rx_o), 0);
		rd(BMC_OFFSET, 32'h2900);
		wr(BMC_OFFSET, 32'h2500);
		cyc(2);
		chk("oe", 32'(mii_rx_oe), 0);
		chk("txiso", 32'(mii_tx_core), 0);
		rd(BMC_OFFSET, 32'h2500);
		rnd <= 0;
		wr(BMC_OFFSET, 32'h2180);
		mii_tx_pin <= 6'h02;
		cyc(5);
		chk("col", 32'(mii_rx_o.col), 1);
		chk("txcore", 32'(mii_tx_core), 32'h02);
		mii_tx_pin <= 6'h00;
		cyc(5);
		chk("col", 32'(mii_rx_o.col), 0);
		wr(BMC_OFFSET, 32'h0000, 4'h1);
		rd(BMC_OFFSET, 32'h2100);
		wr(BMC_OFFSET, 32'h8000);
		chk("srst", 32'(dp_soft_reset), 1);
		rd(BMC_OFFSET, 32'h9000 | ng);
		cyc(25);
		rd(BMC_OFFSET, 32'h1000 | ng);
		stop_test();
	end
endmodule : pbmc_top_tb_top
`default_nettype wire
